// [include/ctmr_defs.svh]
// Contract
// - Count clock comes from prescaler output or event pin
// - Two 8-bit counters, split or cascaded
// - Two identical channels, own pins, registers
// - Low pin: low timer, or 16-bit pair
// - Low enable overrides direction: interval/PWM/PWC
// - High enable overrides direction: interval/fixed-PWM/PWC
// - One event pin feeds both timers
// - Interval/PWM: event input is count clock
// - PWC/capture: event is signal, never clock
// - High timer measures its own event input
// - 16-bit operation ignores high event input
// - Variable PWM keeps high event input usable
// - Low timer has internal signal input
// - Mode bit selects 8-bit or 16-bit
// - Variable PWM forces separate 8-bit counters
// - Channel 1 internal input tied low
`ifndef CTMR_DEFS_SVH
`define CTMR_DEFS_SVH

// Register index inside one channel window
`define CTMR_OFS_CTRLA_LO  3'h0
`define CTMR_OFS_CTRLA_HI  3'h1
`define CTMR_OFS_CTRLB_LO  3'h2
`define CTMR_OFS_CTRLB_HI  3'h3
`define CTMR_OFS_DATA_LO   3'h4
`define CTMR_OFS_DATA_HI   3'h5
`define CTMR_OFS_MODECTL   3'h6
`define CTMR_ADDR_W        4

// Control A fields
`define CTMR_A_IFE         7
`define CTMR_A_CLK_HI      6
`define CTMR_A_CLK_LO      4
`define CTMR_A_MODE_HI     3
`define CTMR_A_MODE_LO     0
// Control B fields
`define CTMR_B_START       7
`define CTMR_B_HOLD        6
`define CTMR_B_IE          5
`define CTMR_B_IF          2
`define CTMR_B_SETOUT      1
`define CTMR_B_OE          0
`define CTMR_B_STORE_MASK  8'he3
// Mode control fields
`define CTMR_M_TOUT1       7
`define CTMR_M_TOUT0       6
`define CTMR_M_INTSEL      5
`define CTMR_M_CASCADE     4
`define CTMR_M_STORE_MASK  8'h3f

// Function codes of the mode field
`define CTMR_FN_ONESHOT    4'h0
`define CTMR_FN_CONT       4'h1
`define CTMR_FN_PWMFIX     4'h3
`define CTMR_FN_PWMVAR     4'h4
`define CTMR_FN_PWC_H      4'h5
`define CTMR_FN_PWC_L      4'h6
`define CTMR_FN_PWC_RR     4'h7
`define CTMR_FN_PWC_FF     4'h8
`define CTMR_FN_PWC_HC     4'h9
`define CTMR_FN_CAP_FIRST  4'ha
`define CTMR_FN_CAP_CLR    4'hd

// Clock select code for the event pin, prescaler width
`define CTMR_CLK_EXT       3'h7
`define CTMR_CLK_INT0      3'h0
`define CTMR_PRESC_W       7
`define CTMR_RST_BYTE      8'h00

`endif

// [include/ctmr_pkg.sv]
package ctmr_pkg;

   // Port logic side of one channel's pins
   typedef struct packed {
      logic [1:0] portDirectionBits; // Bit 1 high pin, bit 0 low pin; 1 = output
      logic [1:0] portDataBits;      // Port output level when the timer does not drive
   } ctmr_port_t;

   // Pin drive of one channel
   typedef struct packed {
      logic lowTimerOutputPin;       // Level on the low output pin
      logic lowTimerOutputEn_n;      // Low while the pin is driven
      logic highTimerOutputPin;      // Level on the high output pin
      logic highTimerOutputEn_n;     // Low while the pin is driven
   } ctmr_pins_t;

   // Timer function classes, one-hot
   typedef enum logic [4:0] {
      CTMR_INTERVAL = 5'h01,
      CTMR_PWMFIX   = 5'h02,
      CTMR_PWMVAR   = 5'h04,
      CTMR_PWC      = 5'h08,
      CTMR_CAPTURE  = 5'h10
   } ctmr_func_t;

endpackage

// [src/ctmr_counter8.sv]
`timescale 1ns/1ps
// One counter stage; cascading two stages gives the wide counter
module ctmr_counter8 #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             rstn,
   input  wire logic             clear,
   input  wire logic             step,
   output logic      [WIDTH-1:0] count,
   output logic                  wrap
);

   // Rollover pulse, used as carry into the next stage
   assign wrap = step & (&count);

   // Clear wins over a step
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         count <= '0;
      end else if (clear) begin
         count <= '0;
      end else if (step) begin
         count <= count + WIDTH'(1);
      end
   end

endmodule

// [src/ctmr_top.sv]
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
`include "ctmr_defs.svh"
// Two channel composite timer with pin routing
module ctmr_top #(
   parameter int CHANNELS = 2
) (
   input  wire logic                                clk_sys,
   input  wire logic                                rstn,
   input  wire logic [`CTMR_ADDR_W-1:0]             regAddr,
   input  wire logic [7:0]                          regWdata,
   input  wire logic                                regWr,
   input  wire logic                                regRd,
   output logic      [7:0]                          regRdata,
   input  wire logic [CHANNELS-1:0]                 channelEventInputPin,
   input  wire logic                                internalSignalInput,
   input  wire ctmr_pkg::ctmr_port_t [CHANNELS-1:0] portCtl,
   output ctmr_pkg::ctmr_pins_t [CHANNELS-1:0]      pinOut
);

   localparam int NT = CHANNELS * 2;           // Timers in the block

   // Values shared between timer slices
   logic [7:0]          ctlAW   [NT];          // Control A per timer
   logic [7:0]          ctlBRdW [NT];          // Control B readback
   logic [7:0]          dataW   [NT];          // Written data per timer
   logic [7:0]          dataRdW [NT];          // Data readback
   logic [7:0]          cntW    [NT];          // Counter values
   logic [NT-1:0]       runW;                  // Start bits
   logic [NT-1:0]       wrapW;                 // Counter rollover pulses
   logic [NT-1:0]       clrW;                  // Counter clears
   logic [NT-1:0]       capEvW;                // Capture strobes
   logic [NT-1:0]       toutW;                 // Timer output levels
   logic [NT-1:0]       driveW;                // Timer owns its pin
   logic [7:0]          modeCtlW [CHANNELS];   // Mode control per channel
   logic [CHANNELS-1:0] cascW;                 // Channel runs 16-bit
   logic [CHANNELS-1:0] evSync;                // Synchronised event pins
   logic [CHANNELS-1:0] intSig;                // Internal signal per channel
   logic [`CTMR_PRESC_W-1:0] presc_r;          // Free-running prescaler
   logic [7:0]          rdata_r;               // Registered read data
   logic [7:0]          rdata_nxt;             // Read data next value

   // Only channel 0 sees the chip-level signal; the others read zero
   always_comb begin
      intSig    = '0;
      intSig[0] = internalSignalInput;
   end

   // Prescaler divides the system clock for the count clock choices
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         presc_r <= '0;
      end else begin
         presc_r <= presc_r + `CTMR_PRESC_W'(1);
      end
   end

   // Tick of the prescaler tap 1/2^sel, one cycle every 2^sel cycles
   function automatic logic prescTick(input logic [2:0] sel, input logic [`CTMR_PRESC_W-1:0] p);
      logic [`CTMR_PRESC_W:0] mask;
      mask = (`CTMR_PRESC_W'(1) << sel) - (`CTMR_PRESC_W+1)'(1);
      prescTick = &(p | ~mask[`CTMR_PRESC_W-1:0]);
   endfunction

   // Per channel: event pin synchroniser, mode control, pin drive
   for (genvar c = 0; c < CHANNELS; c++) begin : gCh
      localparam int LO = c * 2;               // Low timer index
      localparam int HI = c * 2 + 1;           // High timer index
      logic                   evMeta_r;        // First synchroniser stage
      logic                   evSync_r;        // Second synchroniser stage
      logic [7:0]             modeCtl_r;       // Writable mode control bits
      ctmr_pkg::ctmr_pins_t   pins_r;          // Registered pin drive
      ctmr_pkg::ctmr_pins_t   pins_nxt;        // Pin drive next value
      logic                   wrMode;          // Write to mode control

      // Two-stage synchroniser on the external event pin
      always_ff @(posedge clk_sys) begin
         if (!rstn) begin
            evMeta_r <= 1'b0;
            evSync_r <= 1'b0;
         end else begin
            evMeta_r <= channelEventInputPin[c];
            evSync_r <= evMeta_r;
         end
      end
      assign evSync[c] = evSync_r;

      // Mode control write; output status bits are read-only
      assign wrMode = regWr && (regAddr[3] == 1'(c)) && (regAddr[2:0] == `CTMR_OFS_MODECTL);
      always_ff @(posedge clk_sys) begin
         if (!rstn) begin
            modeCtl_r <= `CTMR_RST_BYTE;
         end else if (wrMode) begin
            modeCtl_r <= regWdata & `CTMR_M_STORE_MASK;
         end
      end
      assign modeCtlW[c] = modeCtl_r | {toutW[HI], toutW[LO], 6'h00};

      // Cascade only when selected and the pair is not in variable PWM
      assign cascW[c] = modeCtl_r[`CTMR_M_CASCADE] &&
                        (ctlAW[LO][3:0] != `CTMR_FN_PWMVAR);

      // Timer drive overrides the port direction; else port logic drives
      always_comb begin
         pins_nxt = '0;
         pins_nxt.lowTimerOutputPin   = driveW[LO] ? toutW[LO] : portCtl[c].portDataBits[0];
         pins_nxt.lowTimerOutputEn_n  = ~(driveW[LO] | portCtl[c].portDirectionBits[0]);
         pins_nxt.highTimerOutputPin  = driveW[HI] ? toutW[HI] : portCtl[c].portDataBits[1];
         pins_nxt.highTimerOutputEn_n = ~(driveW[HI] | portCtl[c].portDirectionBits[1]);
      end

      // Pin drive from flip-flops
      always_ff @(posedge clk_sys) begin
         if (!rstn) begin
            pins_r <= '{default: 1'b0, lowTimerOutputEn_n: 1'b1, highTimerOutputEn_n: 1'b1};
         end else begin
            pins_r <= pins_nxt;
         end
      end
      assign pinOut[c] = pins_r;
   end

   // Per timer: control registers, counter, function logic
   for (genvar k = 0; k < NT; k++) begin : gTmr
      localparam int C  = k / 2;               // Channel of this timer
      localparam int T  = k % 2;               // 0 low timer, 1 high timer
      localparam int LO = C * 2;               // Low timer of this channel
      localparam int PT = k ^ 1;               // Partner timer
      logic [7:0]  ctlA_r;                     // Mode, clock select, IF enable
      logic [7:0]  ctlB_r;                     // Start, enables, flag
      logic [7:0]  data_r;                     // Compare or cycle value
      logic [7:0]  cap_r;                      // Captured count
      logic        out_r;                      // Interval toggle output
      logic        act_r;                      // Pulse measurement in progress
      logic        evPrev_r;                   // Event level one cycle back
      logic        follow;                     // High half of a cascade
      logic        wide;                       // Low half of a cascade
      logic [7:0]  ctl;                        // Control A in effect
      logic [3:0]  mode;                       // Function code in effect
      ctmr_pkg::ctmr_func_t fn;                // Function class
      logic        run, ev, rise, fall;        // Start, event level and edges
      logic        tick, step, clr, match;     // Counter control
      logic        startEv, endEv, capEdge;    // Measurement edges
      logic        capEv, hit, flagSet, wrapEv;
      logic        wrA, wrB, wrD;              // Register write strobes
      logic [15:0] cmpCnt, cmpDat;             // Compare operands
      logic [2:0]  clkNew;                     // Clock select to store
      logic        newMeas;                    // Written mode is PWC or capture

      assign follow = (T == 1) && cascW[C];
      assign wide   = (T == 0) && cascW[C];
      assign ctl    = follow ? ctlAW[LO] : ctlA_r;
      assign mode   = ctl[`CTMR_A_MODE_HI:`CTMR_A_MODE_LO];
      assign run    = follow ? runW[LO] : ctlB_r[`CTMR_B_START];

      // Decode the function class
      always_comb begin
         if (mode < `CTMR_FN_PWMFIX) begin
            fn = ctmr_pkg::CTMR_INTERVAL;
         end else if (mode == `CTMR_FN_PWMFIX) begin
            fn = ctmr_pkg::CTMR_PWMFIX;
         end else if (mode == `CTMR_FN_PWMVAR) begin
            fn = ctmr_pkg::CTMR_PWMVAR;
         end else if (mode < `CTMR_FN_CAP_FIRST) begin
            fn = ctmr_pkg::CTMR_PWC;
         end else begin
            fn = ctmr_pkg::CTMR_CAPTURE;
         end
      end

      // Event source: both timers share the pin; low may take the internal signal
      if (T == 0) begin : gEvLo
         assign ev = modeCtlW[C][`CTMR_M_INTSEL] ? intSig[C] : evSync[C];
      end else begin : gEvHi
         assign ev = cascW[C] ? 1'b0 : evSync[C];
      end
      assign rise = ev & ~evPrev_r;
      assign fall = ~ev & evPrev_r;

      // Edge detector history
      always_ff @(posedge clk_sys) begin
         if (!rstn) begin
            evPrev_r <= 1'b0;
         end else begin
            evPrev_r <= ev;
         end
      end

      // Count clock: carry in cascade, event edge, or a prescaler tap
      always_comb begin
         if (follow) begin
            tick = wrapW[LO];
         end else if (ctl[`CTMR_A_CLK_HI:`CTMR_A_CLK_LO] == `CTMR_CLK_EXT) begin
            tick = rise && (fn != ctmr_pkg::CTMR_PWC) && (fn != ctmr_pkg::CTMR_CAPTURE);
         end else begin
            tick = prescTick(ctl[`CTMR_A_CLK_HI:`CTMR_A_CLK_LO], presc_r);
         end
      end
      assign step = run && tick && ((fn != ctmr_pkg::CTMR_PWC) || act_r);

      // Measurement edges per function code
      always_comb begin
         startEv = 1'b0;
         endEv   = 1'b0;
         case (mode)
            `CTMR_FN_PWC_H, `CTMR_FN_PWC_HC: begin
               startEv = rise;
               endEv   = fall;
            end
            `CTMR_FN_PWC_L: begin
               startEv = fall;
               endEv   = rise;
            end
            `CTMR_FN_PWC_RR: begin
               startEv = rise;
               endEv   = rise;
            end
            `CTMR_FN_PWC_FF: begin
               startEv = fall;
               endEv   = fall;
            end
            default: begin
               startEv = 1'b0;
               endEv   = 1'b0;
            end
         endcase
      end
      assign capEdge = ((mode == 4'ha) || (mode == 4'hd)) ? rise :
                       ((mode == 4'hb) || (mode == 4'he)) ? fall : (rise | fall);

      // Event input of each timer is its own measured signal
      assign capEv = !follow && run &&
                     (((fn == ctmr_pkg::CTMR_PWC) && endEv && act_r) ||
                      ((fn == ctmr_pkg::CTMR_CAPTURE) && capEdge));

      // Compare operands, widened in cascade
      assign cmpCnt = wide ? {cntW[LO+1], cntW[k]} : {8'h00, cntW[k]};
      assign cmpDat = wide ? {dataW[LO+1], data_r} : {8'h00, data_r};
      assign match  = (cmpCnt == cmpDat);
      assign hit    = !follow && step && match && (fn == ctmr_pkg::CTMR_INTERVAL);
      assign wrapEv = wide ? wrapW[LO+1] : wrapW[k];

      // Counter clear: stopped, interval reload, PWM cycle end, measurement start
      assign clr = follow ? clrW[LO] :
                   (!run ||
                    (hit && (mode == `CTMR_FN_CONT)) ||
                    (step && match && (fn == ctmr_pkg::CTMR_PWMVAR)) ||
                    ((fn == ctmr_pkg::CTMR_PWC) && startEv) ||
                    ((fn == ctmr_pkg::CTMR_CAPTURE) && (mode >= `CTMR_FN_CAP_CLR) && capEdge));

      ctmr_counter8 #(
         .WIDTH (8)
      ) uCnt (
         .clk_sys (clk_sys),
         .rstn    (rstn),
         .clear   (clr),
         .step    (step),
         .count   (cntW[k]),
         .wrap    (wrapW[k])
      );

      // Flag events of this timer
      assign flagSet = hit || capEv ||
                       (!follow && (fn == ctmr_pkg::CTMR_PWMFIX) && wrapEv) ||
                       (!follow && step && match && (fn == ctmr_pkg::CTMR_PWMVAR));

      // Register write strobes of this timer
      assign wrA = regWr && (regAddr[3] == C[0]) && (regAddr[2:0] == (`CTMR_OFS_CTRLA_LO + 3'(T)));
      assign wrB = regWr && (regAddr[3] == C[0]) && (regAddr[2:0] == (`CTMR_OFS_CTRLB_LO + 3'(T)));
      assign wrD = regWr && (regAddr[3] == C[0]) && (regAddr[2:0] == (`CTMR_OFS_DATA_LO + 3'(T)));
      assign newMeas = (regWdata[3:0] >= `CTMR_FN_PWC_H);
      assign clkNew  = (newMeas && (regWdata[6:4] == `CTMR_CLK_EXT)) ? `CTMR_CLK_INT0 : regWdata[6:4];

      // Control A: locked while running; clock select frozen in cascade high half
      always_ff @(posedge clk_sys) begin
         if (!rstn) begin
            ctlA_r <= `CTMR_RST_BYTE;
         end else if (wrA && !ctlB_r[`CTMR_B_START]) begin
            ctlA_r[`CTMR_A_IFE] <= regWdata[`CTMR_A_IFE];
            ctlA_r[`CTMR_A_MODE_HI:`CTMR_A_MODE_LO] <= regWdata[3:0];
            if (!follow) begin
               ctlA_r[`CTMR_A_CLK_HI:`CTMR_A_CLK_LO] <= clkNew;
            end
         end
      end

      // Control B: one-shot end stops; a flag set beats a clear
      always_ff @(posedge clk_sys) begin
         if (!rstn) begin
            ctlB_r <= `CTMR_RST_BYTE;
         end else begin
            if (wrB) begin
               ctlB_r <= (regWdata & `CTMR_B_STORE_MASK) | {5'h00, ctlB_r[`CTMR_B_IF], 2'h0};
               if (!regWdata[`CTMR_B_IF]) begin
                  ctlB_r[`CTMR_B_IF] <= 1'b0;
               end
            end else if (hit && (mode == `CTMR_FN_ONESHOT)) begin
               ctlB_r[`CTMR_B_START] <= 1'b0;
            end
            if (flagSet) begin
               ctlB_r[`CTMR_B_IF] <= 1'b1;
            end
         end
      end

      // Interval output: toggles on match, preset while stopped
      always_ff @(posedge clk_sys) begin
         if (!rstn) begin
            out_r <= 1'b0;
         end else if (wrB && !ctlB_r[`CTMR_B_START]) begin
            out_r <= regWdata[`CTMR_B_SETOUT];
         end else if (hit) begin
            out_r <= ~out_r;
         end
      end

      // Measurement window: opened by start edge, closed by end edge in high or low pulse mode only
      always_ff @(posedge clk_sys) begin
         if (!rstn) begin
            act_r <= 1'b0;
         end else if (!run || (fn != ctmr_pkg::CTMR_PWC)) begin
            act_r <= 1'b0;
         end else if (startEv) begin
            act_r <= 1'b1;
         end else if (capEv && ((mode == `CTMR_FN_PWC_H) || (mode == `CTMR_FN_PWC_L))) begin
            act_r <= 1'b0;
         end
      end

      // Data register and capture register
      always_ff @(posedge clk_sys) begin
         if (!rstn) begin
            data_r <= `CTMR_RST_BYTE;
            cap_r  <= `CTMR_RST_BYTE;
         end else begin
            if (wrD) begin
               data_r <= regWdata;
            end
            if (capEv || (follow && capEvW[LO])) begin
               cap_r <= cntW[k];
            end
         end
      end

      // Output level by function
      always_comb begin
         case (fn)
            ctmr_pkg::CTMR_INTERVAL: toutW[k] = out_r;
            ctmr_pkg::CTMR_PWMFIX:   toutW[k] = (cmpCnt < cmpDat);
            ctmr_pkg::CTMR_PWMVAR:   toutW[k] = (cntW[k] >= dataW[PT]);
            ctmr_pkg::CTMR_PWC:      toutW[k] = act_r;
            default:                 toutW[k] = 1'b0;
         endcase
      end

      // Pin ownership: high pin is released in cascade and variable PWM
      if (T == 0) begin : gDrvLo
         assign driveW[k] = ctlB_r[`CTMR_B_OE] && (fn != ctmr_pkg::CTMR_CAPTURE);
      end else begin : gDrvHi
         assign driveW[k] = ctlB_r[`CTMR_B_OE] && !cascW[C] &&
                            (fn != ctmr_pkg::CTMR_CAPTURE) && (fn != ctmr_pkg::CTMR_PWMVAR);
      end

      assign ctlAW[k]   = ctlA_r;
      assign ctlBRdW[k] = ctlB_r;
      assign dataW[k]   = data_r;
      assign dataRdW[k] = ((fn == ctmr_pkg::CTMR_PWC) || (fn == ctmr_pkg::CTMR_CAPTURE)) ? cap_r : data_r;
      assign runW[k]    = ctlB_r[`CTMR_B_START];
      assign clrW[k]    = clr;
      assign capEvW[k]  = capEv;
   end

   // Read decode; unmapped index reads zero
   always_comb begin
      rdata_nxt = 8'h00;
      case (regAddr[2:0])
         `CTMR_OFS_CTRLA_LO: rdata_nxt = ctlAW[regAddr[3] * 2];
         `CTMR_OFS_CTRLA_HI: rdata_nxt = ctlAW[regAddr[3] * 2 + 1];
         `CTMR_OFS_CTRLB_LO: rdata_nxt = ctlBRdW[regAddr[3] * 2];
         `CTMR_OFS_CTRLB_HI: rdata_nxt = ctlBRdW[regAddr[3] * 2 + 1];
         `CTMR_OFS_DATA_LO:  rdata_nxt = dataRdW[regAddr[3] * 2];
         `CTMR_OFS_DATA_HI:  rdata_nxt = dataRdW[regAddr[3] * 2 + 1];
         `CTMR_OFS_MODECTL:  rdata_nxt = modeCtlW[regAddr[3]];
         default:            rdata_nxt = 8'h00;
      endcase
   end

   // Read data stands in the cycle after the strobe only
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rdata_r <= 8'h00;
      end else if (regRd) begin
         rdata_r <= rdata_nxt;
      end else begin
         rdata_r <= 8'h00;
      end
   end
   assign regRdata = rdata_r;

endmodule

// [tb/composite_timer_pin_routing_tb.sv]
`timescale 1ns/1ps
module composite_timer_pin_routing_tb;
   logic clk_sys = 1'b0, rstn = 1'b0, regWr = 1'b0, regRd = 1'b0;
   logic [3:0] regAddr = 4'h0, dirReq = 4'h0, padLevel;
   logic [7:0] regWdata = 8'h00, regRdata;
   logic [1:0] evtReq = 2'b00, channelEventInputPin;
   ctmr_pkg::ctmr_port_t [1:0] portCtl;
   ctmr_pkg::ctmr_pins_t [1:0] pinOut;
   int error_cnt = 0, comparisons = 0;
   localparam logic [3:0] HI_FN [5] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'ha}; // Functions tried on a pin
   localparam logic [3:0] LO_FN [5] = '{4'h0, 4'h3, 4'h4, 4'h7, 4'hd};
   localparam logic [4:0] HI_EN = 5'b10100, LO_EN = 5'b10000; // Expected enable, one bit per entry
   ctmr_top dut (.clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .channelEventInputPin(channelEventInputPin),
      .internalSignalInput(evtReq[1]), .portCtl(portCtl), .pinOut(pinOut));
   ctmr_pin_model model (.dirReq(dirReq), .evtReq(evtReq), .pinOut(pinOut),
      .portCtl(portCtl), .channelEventInputPin(channelEventInputPin), .padLevel(padLevel));
   // Clock, 100 ns period
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end
   task chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1 chk(regRdata, e);
   endtask
   task settle();
      repeat (4) @(posedge clk_sys);
      #1;
   endtask
   task pulse(input logic [1:0] m);
      @(posedge clk_sys);
      evtReq <= m;
      repeat (4) @(posedge clk_sys);
      evtReq <= 2'b00;
      repeat (4) @(posedge clk_sys);
      #1;
   endtask
   task report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      rd(4'h7, 8'h00);
      rd(4'hc, 8'h00);
      wr(4'h9, 8'h75);
      rd(4'h9, 8'h05);
      $display("test registers done");
      for (int i = 0; i < 5; i++) begin
         wr(4'h9, {4'h0, HI_FN[i]});
         wr(4'hb, 8'h01);
         settle();
         chk({7'h0, pinOut[1].highTimerOutputEn_n}, {7'h0, HI_EN[i]});
      end
      wr(4'h9, 8'h01);
      wr(4'he, 8'h10);
      settle();
      chk({7'h0, pinOut[1].highTimerOutputEn_n}, 8'h01);
      rd(4'he, 8'h10);
      $display("test high pin done");
      for (int i = 0; i < 5; i++) begin
         wr(4'h2, {7'h0, ~LO_EN[i]});
         wr(4'h0, {4'h0, LO_FN[i]});
         settle();
         chk({7'h0, pinOut[0].lowTimerOutputEn_n}, {7'h0, LO_EN[i]});
      end
      $display("test low pin done");
      wr(4'hb, 8'h00);
      dirReq <= 4'b1001;
      settle();
      chk({6'h0, padLevel[3], pinOut[1].highTimerOutputEn_n}, 8'h00);
      chk({7'h0, pinOut[0].lowTimerOutputEn_n}, 8'h00);
      dirReq <= 4'h0;
      $display("test direction done");
      wr(4'h0, 8'h71);
      wr(4'h1, 8'h71);
      wr(4'h4, 8'h02);
      wr(4'h5, 8'h02);
      wr(4'h2, 8'h81);
      wr(4'h3, 8'h81);
      repeat (2) pulse(2'b01);
      chk({6'h0, padLevel[1:0]}, 8'h00);
      pulse(2'b01);
      chk({6'h0, padLevel[1:0]}, 8'h03);
      wr(4'h6, 8'h20);
      repeat (3) pulse(2'b10);
      chk({6'h0, padLevel[1:0]}, 8'h02);
      $display("test event clock done");
      report_and_stop();
   end
endmodule

// [tb/ctmr_pin_model.sv]
`timescale 1ns/1ps
// Port logic and pads around both channels
module ctmr_pin_model (
   input wire logic [3:0]                dirReq,
   input wire logic [1:0]                evtReq,
   input wire ctmr_pkg::ctmr_pins_t [1:0] pinOut,
   output ctmr_pkg::ctmr_port_t [1:0]    portCtl,
   output logic [1:0]                    channelEventInputPin,
   output logic [3:0]                    padLevel
);
   localparam logic [1:0] EC_DIR = 2'b00; // Event pins kept as port inputs
   // Event pin reaches the timer only while its port bit is input
   assign channelEventInputPin = evtReq & ~EC_DIR;
   // Pads: driven level, else pull-up
   for (genvar c = 0; c < 2; c++) begin : g_pad
      assign portCtl[c] = {dirReq[2*c+1], dirReq[2*c], 2'b01};
      assign padLevel[2*c] = pinOut[c].lowTimerOutputEn_n ? 1'b1 : pinOut[c].lowTimerOutputPin;
      assign padLevel[2*c+1] = pinOut[c].highTimerOutputEn_n ? 1'b1 : pinOut[c].highTimerOutputPin;
   end
endmodule

// [tb/ctmr_top_properties.sv]
`timescale 1ns/1ps
// Port-level checker for the composite timer
module ctmr_props #(
   parameter int CHANNELS = 2
) (
   input wire logic                                clk_sys,
   input wire logic                                rstn,
   input wire logic [3:0]                          regAddr,
   input wire logic [7:0]                          regWdata,
   input wire logic                                regWr,
   input wire logic                                regRd,
   input wire logic [7:0]                          regRdata,
   input wire logic [CHANNELS-1:0]                 channelEventInputPin,
   input wire logic                                internalSignalInput,
   input wire ctmr_pkg::ctmr_port_t [CHANNELS-1:0] portCtl,
   input wire ctmr_pkg::ctmr_pins_t [CHANNELS-1:0] pinOut
);
   logic [11:0] shadow_r; // 3:0 ch0 low function, 4 low OE, 5 ever started, 11:6 ch1 mode
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // Shadow of channel 0 low set-up and channel 1 mode bits
   always_ff @(posedge clk_sys) begin
      if (!rstn)
         shadow_r <= 12'h000;
      else if (regWr && regAddr == 4'h0)
         shadow_r[3:0] <= regWdata[3:0];
      else if (regWr && regAddr == 4'h2)
         shadow_r[5:4] <= {shadow_r[5] | regWdata[7], regWdata[0]};
      else if (regWr && regAddr == 4'he)
         shadow_r[11:6] <= regWdata[5:0];
   end
   rd_idle_a: assert property (!regRd |=> regRdata == 8'h00) else $error("read data not idle");
   unmapped_zero_a: assert property (regRd && regAddr[2:0] == 3'h7 |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
   ctrlb_gap_a: assert property (regRd && regAddr[2:1] == 2'b01 |=> regRdata[4:3] == 2'b00)
      else $error("control B gap bits set");
   mode_back_a: assert property (regRd && regAddr == 4'he |=> regRdata[5:0] == $past(shadow_r[11:6]))
      else $error("mode control readback wrong");
   low_dir_a: assert property (portCtl[0].portDirectionBits[0] |=> !pinOut[0].lowTimerOutputEn_n)
      else $error("low pin not driven");
   high_dir_a: assert property (portCtl[1].portDirectionBits[1] |=> !pinOut[1].highTimerOutputEn_n)
      else $error("high pin not driven");
   low_override_a: assert property (!shadow_r[5] && shadow_r[4] && shadow_r[3:0] < 4'ha
      |=> !pinOut[0].lowTimerOutputEn_n) else $error("low output enable ignored");
   capture_quiet_a: assert property (!shadow_r[5] && shadow_r[3:0] >= 4'ha && !portCtl[0].portDirectionBits[0]
      |=> pinOut[0].lowTimerOutputEn_n) else $error("capture drives low pin");
   cover property (regRd && regAddr == 4'he);
   cover property (shadow_r[4] && shadow_r[3:0] >= 4'ha);
   cover property (regWr && regAddr == 4'h9);
endmodule
bind ctmr_top ctmr_props #(.CHANNELS(CHANNELS)) u_props (.clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr),
   .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .portCtl(portCtl), .pinOut(pinOut),
   .channelEventInputPin(channelEventInputPin), .internalSignalInput(internalSignalInput));
